// ---- verilog/rasr_top.v ----
// Reference action registers, phase offset stepping, monitor
// bits and EEPROM status readback behind a Wishbone slave.
// Assumes all inputs come from logic on clk_i.
//
// Notes on behaviour
// [RQ1] A-side clear bits drop matching pending flags
// [RQ2] B-side clear bits drop matching pending flags
// [RQ3] Phase bit 2 zeroes the offset
// [RQ4] Phase bit 1 subtracts the step size
// [RQ5] Phase bit 0 adds the step size
// [RQ6] All action bits clear themselves after writes
// [RQ7] Launch bits start per-reference profile selection
// [RQ8] Timeout bits emulate validation timer expiry
// [RQ9] Override bits override reference fault, default off
// [RQ10] Skip bits bypass reference monitor, default off
// [RQ11] Status readback range ignores all writes
// [RQ12] Status stays readable during EEPROM work
// [RQ13] Status bit 2 flags EEPROM fault
// [RQ14] Status bit 1 set while loading
// [RQ15] Status bit 0 set while saving
// [RQ16] Spare clear addresses do nothing
// [RQ17] Monitor bits set only by unmasked events
// [RQ18] Clear bit matches monitor bit position
// [RQ19] Zero writes inert, unused bits read zero
`include "rasr_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module rasr_top #(
    parameter PH_W = 32                    // Offset width, above 16
) (
    input  wire            clk_i,          // Clock, 20 MHz
    input  wire            rst_i,          // Sync reset
    input  wire            ce_i,           // Clock enable

    input  wire            wb_cyc_i,       // Bus cycle
    input  wire            wb_stb_i,       // Strobe
    input  wire            wb_we_i,        // Write enable
    input  wire [13:0]     wb_adr_i,       // Byte address
    input  wire [3:0]      wb_sel_i,       // Byte selects
    input  wire [31:0]     wb_dat_i,       // Write data
    output wire [31:0]     wb_dat_o,       // Read data
    output wire            wb_ack_o,       // Acknowledge

    input  wire [15:0]     ref_event_i,    // Reference events
    input  wire            irq_reset_all_i,// Global IRQ clear
    input  wire            ee_fault_i,     // EEPROM fault seen
    input  wire            ee_load_i,      // EEPROM load busy
    input  wire            ee_save_i,      // EEPROM save busy

    output reg             irq_o,          // Interrupt level
    output reg  [PH_W-1:0] phase_offset_o, // Incremental offset
    output reg  [3:0]      launch_o,       // Profile select start
    output reg  [3:0]      timeout_o,      // Forced timeout
    output reg  [3:0]      override_o,     // Fault override
    output reg  [3:0]      skip_o          // Monitor bypass
);

    ////////////////////////////////////////////////////////////////
    // Address decode

    // Word index map of the bank (byte address is four times it):
    //   a08  A-side clear, one bit per pending flag
    //   a09  B-side clear, one bit per pending flag
    //   a0a  Spare clear, no function
    //   a0b  Spare clear, no function
    //   a0c  Phase control: bit 2 zero, bit 1 down, bit 0 up
    //   a0d  Profile selection launch, one bit per input
    //   a0e  Forced validation timeout, one bit per input
    //   a0f  Fault override, one bit per input
    //   a10  Monitor bypass, one bit per input
    //   d00  EEPROM status, read only
    //   d06  A-side monitor flags, read only
    //   d07  B-side monitor flags, read only
    //   20d  A-side event enables, read and write
    //   20e  B-side event enables, read and write
    //   314  Step size low byte, read and write
    //   315  Step size high byte, read and write
    // Action registers always read back as zero.

    // Match a bus index against a register index
    function hit;
        input [`RASR_IDX_W-1:0] a;
        input [`RASR_IDX_W-1:0] t;
        begin
            hit = (a == t);
        end
    endfunction

    wire [`RASR_IDX_W-1:0] idx;           // Word index
    wire                   wr_en;         // Write strobe
    wire [7:0]             wd;            // Write byte
    reg  [7:0]             rd_data;       // Read mux
    wire                   ro_range;      // Status range

    assign idx = wb_adr_i[13:2];
    assign wd  = wb_dat_i[7:0];

    // Whole status range, write-protected below
    assign ro_range = (idx >= `RASR_IDX_RO_LO)
                    && (idx <= `RASR_IDX_RO_HI);

    ////////////////////////////////////////////////////////////////
    // Bus front end

    // Every access is acknowledged one cycle after it is taken,
    // mapped or not; there is no error response.
    rasr_wb_slave u_bus (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_we_i   (wb_we_i),
        .wb_sel_i  (wb_sel_i),
        .rd_data_i (rd_data),
        .wb_dat_o  (wb_dat_o),
        .wb_ack_o  (wb_ack_o),
        .wr_en_o   (wr_en)
    );

    // Write strobe per register; status range never written
    wire w_a_clr;                          // A-side clear
    wire w_b_clr;                          // B-side clear
    wire w_ph;                             // Phase control
    wire w_launch;                         // Profile launch
    wire w_tmo;                            // Forced timeout
    wire w_ovr;                            // Override
    wire w_skip;                           // Bypass
    wire w_mask_a;                         // A mask
    wire w_mask_b;                         // B mask
    wire w_step_lo;                        // Step low byte
    wire w_step_hi;                        // Step high byte
    wire wr_ok;                            // Write allowed

    assign wr_ok     = wr_en & ~ro_range;  // [RQ11]
    assign w_a_clr   = wr_ok & hit(idx, `RASR_IDX_A_CLR);
    assign w_b_clr   = wr_ok & hit(idx, `RASR_IDX_B_CLR);
    assign w_ph      = wr_ok & hit(idx, `RASR_IDX_PH_CTRL);
    assign w_launch  = wr_ok & hit(idx, `RASR_IDX_LAUNCH);
    assign w_tmo     = wr_ok & hit(idx, `RASR_IDX_TIMEOUT);
    assign w_ovr     = wr_ok & hit(idx, `RASR_IDX_OVERRIDE);
    assign w_skip    = wr_ok & hit(idx, `RASR_IDX_SKIP);
    assign w_mask_a  = wr_ok & hit(idx, `RASR_IDX_MASK_A);
    assign w_mask_b  = wr_ok & hit(idx, `RASR_IDX_MASK_B);
    assign w_step_lo = wr_ok & hit(idx, `RASR_IDX_STEP_LO);
    assign w_step_hi = wr_ok & hit(idx, `RASR_IDX_STEP_HI);
    // Spare clear indices decode to nothing at all [RQ16]

    ////////////////////////////////////////////////////////////////
    // Plain storage registers

    reg [7:0]  mask_a;                     // A-side enables
    reg [7:0]  mask_b;                     // B-side enables
    reg [15:0] step;                       // Phase step size
    reg [2:0]  ee_stat;                    // EEPROM status copy

    // Enable masks gate both flag setting and the interrupt.
    // Masks and step size, written byte by byte
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mask_a <= `RASR_ZERO8;
            mask_b <= `RASR_ZERO8;
            step   <= `RASR_ZERO16;
        end
        else if (ce_i)
        begin
            if (w_mask_a)
                mask_a <= wd;
            if (w_mask_b)
                mask_b <= wd;
            if (w_step_lo)
                step[7:0] <= wd;
            if (w_step_hi)
                step[15:8] <= wd;
        end
    end

    // One cycle of delay on these bits is harmless, since
    // software polls them far slower than they change.
    // Sample EEPROM state; no bus gating during transfers
    always @(posedge clk_i)
    begin
        if (rst_i)
            ee_stat <= `RASR_EE_ZERO;
        else if (ce_i)
        begin
            ee_stat[`RASR_EE_FAULT] <= ee_fault_i; // [RQ13]
            ee_stat[`RASR_EE_LOAD]  <= ee_load_i;  // [RQ14]
            ee_stat[`RASR_EE_SAVE]  <= ee_save_i;  // [RQ15]
        end
    end

    ////////////////////////////////////////////////////////////////
    // Self-clearing action pulses

    // Bit order of all four action outputs:
    //   bit 3  Second B-side input
    //   bit 2  First B-side input
    //   bit 1  Second A-side input
    //   bit 0  First A-side input
    // Override and bypass are one-cycle pulses here; a consumer
    // that needs a level must hold its own copy.
    // Pulse for one cycle per written one, then back to zero
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            launch_o   <= `RASR_ZERO4;
            timeout_o  <= `RASR_ZERO4;
            override_o <= `RASR_ZERO4;     // [RQ9]
            skip_o     <= `RASR_ZERO4;     // [RQ10]
        end
        else if (ce_i)
        begin
            launch_o   <= w_launch ? wd[3:0] : `RASR_ZERO4; // [RQ7] [RQ6]
            timeout_o  <= w_tmo    ? wd[3:0] : `RASR_ZERO4; // [RQ8]
            override_o <= w_ovr    ? wd[3:0] : `RASR_ZERO4; // [RQ9]
            skip_o     <= w_skip   ? wd[3:0] : `RASR_ZERO4; // [RQ10]
        end
    end
    // Zero bits yield no pulse, so zero writes are inert [RQ6] [RQ19]

    ////////////////////////////////////////////////////////////////
    // Incremental phase offset

    wire [PH_W-1:0] step_ext;              // Zero-extended step
    wire            ph_rst;                // Zero request
    wire            ph_dec;                // Step down
    wire            ph_inc;                // Step up
    reg  [PH_W-1:0] next_phase;            // Next offset

    assign step_ext = {{(PH_W-16){1'b0}}, step};
    assign ph_rst   = w_ph & wd[`RASR_PH_RESET]; // [RQ6]
    assign ph_dec   = w_ph & wd[`RASR_PH_DEC];
    assign ph_inc   = w_ph & wd[`RASR_PH_INC];

    // Zero wins; up and down together cancel out
    always @*
    begin
        next_phase = phase_offset_o;
        if (ph_rst)
            next_phase = {PH_W{1'b0}};                   // [RQ3]
        else if (ph_dec && !ph_inc)
            next_phase = phase_offset_o - step_ext;      // [RQ4]
        else if (ph_inc && !ph_dec)
            next_phase = phase_offset_o + step_ext;      // [RQ5]
    end

    // Limitation: no saturation, a long run of steps in one
    // direction wraps the offset around.
    // Offset wraps in two's complement
    always @(posedge clk_i)
    begin
        if (rst_i)
            phase_offset_o <= {PH_W{1'b0}};
        else if (ce_i)
            phase_offset_o <= next_phase;
    end

    ////////////////////////////////////////////////////////////////
    // Reference interrupt monitor bits

    // Bit layout of each monitor byte, same as its clear byte:
    //   bit 7  Second input, new profile
    //   bit 6  Second input, validated
    //   bit 5  Second input, fault cleared
    //   bit 4  Second input, fault
    //   bit 3  First input, new profile
    //   bit 2  First input, validated
    //   bit 1  First input, fault cleared
    //   bit 0  First input, fault
    wire [7:0] mon_a;                      // A-side monitor
    wire [7:0] mon_b;                      // B-side monitor
    wire [7:0] clr_a;                      // A-side clears
    wire [7:0] clr_b;                      // B-side clears

    assign clr_a = w_a_clr ? wd : `RASR_ZERO8;            // [RQ1]
    assign clr_b = w_b_clr ? wd : `RASR_ZERO8;            // [RQ2]

    // Clear and event in one cycle leave the flag set, so
    // software never loses an event it has not yet seen.
    // The global clear reaches both groups at once.
    rasr_irq_ref #(
        .W (8)
    ) u_irq_a (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .event_i     (ref_event_i[7:0]),
        .mask_i      (mask_a),
        .clear_i     (clr_a),
        .clear_all_i (irq_reset_all_i),
        .mon_o       (mon_a)
    );

    rasr_irq_ref #(
        .W (8)
    ) u_irq_b (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .event_i     (ref_event_i[15:8]),
        .mask_i      (mask_b),
        .clear_i     (clr_b),
        .clear_all_i (irq_reset_all_i),
        .mon_o       (mon_b)
    );

    // Level interrupt while any enabled flag stands
    always @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else if (ce_i)
            irq_o <= |((mon_a & mask_a) | (mon_b & mask_b));
    end

    ////////////////////////////////////////////////////////////////
    // Read mux

    // No wait states and no gating here: status stays readable
    // while an EEPROM load or save is running.
    // Action registers read zero; unmapped reads zero too
    always @*
    begin
        rd_data = `RASR_ZERO8;
        if (hit(idx, `RASR_IDX_EE_STAT))
            rd_data = {`RASR_PAD5, ee_stat}; // [RQ12] [RQ19]
        else if (hit(idx, `RASR_IDX_MON_A))
            rd_data = mon_a;
        else if (hit(idx, `RASR_IDX_MON_B))
            rd_data = mon_b;
        else if (hit(idx, `RASR_IDX_MASK_A))
            rd_data = mask_a;
        else if (hit(idx, `RASR_IDX_MASK_B))
            rd_data = mask_b;
        else if (hit(idx, `RASR_IDX_STEP_LO))
            rd_data = step[7:0];
        else if (hit(idx, `RASR_IDX_STEP_HI))
            rd_data = step[15:8];
    end

endmodule // rasr_top
`default_nettype wire

// ---- inc/rasr_defines.vh ----
// Constants for the reference action and status register bank.
// Assumes register indices are word indices on a 32-bit bus.
`ifndef RASR_DEFINES_VH
`define RASR_DEFINES_VH
// Register indices (byte address is four times the index)
`define RASR_IDX_W        12
`define RASR_IDX_A_CLR    12'ha08
`define RASR_IDX_B_CLR    12'ha09
`define RASR_IDX_SPARE_LO 12'ha0a
`define RASR_IDX_SPARE_HI 12'ha0b
`define RASR_IDX_PH_CTRL  12'ha0c
`define RASR_IDX_LAUNCH   12'ha0d
`define RASR_IDX_TIMEOUT  12'ha0e
`define RASR_IDX_OVERRIDE 12'ha0f
`define RASR_IDX_SKIP     12'ha10
`define RASR_IDX_EE_STAT  12'hd00
`define RASR_IDX_RO_LO    12'hd00
`define RASR_IDX_RO_HI    12'hd19
`define RASR_IDX_MON_A    12'hd06
`define RASR_IDX_MON_B    12'hd07
`define RASR_IDX_MASK_A   12'h20d
`define RASR_IDX_MASK_B   12'h20e
`define RASR_IDX_STEP_LO  12'h314
`define RASR_IDX_STEP_HI  12'h315
// Field positions
`define RASR_PH_RESET     2
`define RASR_PH_DEC       1
`define RASR_PH_INC       0
`define RASR_EE_FAULT     2
`define RASR_EE_LOAD      1
`define RASR_EE_SAVE      0
// Reset values and fillers
`define RASR_ZERO4        4'h0
`define RASR_ZERO8        8'h00
`define RASR_ZERO16       16'h0000
`define RASR_PAD24        24'h000000
`define RASR_EE_ZERO      3'h0
`define RASR_PAD5         5'h00
`endif

// ---- verilog/rasr_irq_ref.v ----
// Sticky interrupt monitor bits for one group of reference events.
// Assumes events are one-cycle pulses from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rasr_irq_ref #(
    parameter W = 8                        // Number of monitor bits
) (
    input  wire         clk_i,             // Clock
    input  wire         rst_i,             // Sync reset
    input  wire         ce_i,              // Clock enable
    input  wire [W-1:0] event_i,           // Event pulses
    input  wire [W-1:0] mask_i,            // 1 lets the event in
    input  wire [W-1:0] clear_i,           // Write-one clear pulses
    input  wire         clear_all_i,       // Global clear pulse
    output reg  [W-1:0] mon_o              // Monitor bits
);
    ////////////////////////////////////////////////////////////////
    wire [W-1:0] set_bits;                 // Unmasked events
    wire [W-1:0] clr_bits;                 // Combined clears

    assign set_bits = event_i & mask_i;    // [RQ17]
    assign clr_bits = clear_i | {W{clear_all_i}};

    // Set beats clear so a coincident event is never lost
    always @(posedge clk_i)
    begin
        if (rst_i)
            mon_o <= {W{1'b0}};                           // [RQ17]
        else if (ce_i)
            mon_o <= (mon_o & ~clr_bits) | set_bits;      // [RQ18]
    end
endmodule // rasr_irq_ref
`default_nettype wire

// ---- verilog/rasr_wb_slave.v ----
// Classic Wishbone slave front end for 8-bit registers.
// Assumes the master holds its request until it samples ack.
`include "rasr_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module rasr_wb_slave (
    input  wire        clk_i,              // Clock
    input  wire        rst_i,              // Sync reset
    input  wire        ce_i,               // Clock enable
    input  wire        wb_cyc_i,           // Bus cycle
    input  wire        wb_stb_i,           // Strobe
    input  wire        wb_we_i,            // Write enable
    input  wire [3:0]  wb_sel_i,           // Byte selects
    input  wire [7:0]  rd_data_i,          // Read data from bank
    output reg  [31:0] wb_dat_o,           // Read data
    output reg         wb_ack_o,           // Acknowledge
    output wire        wr_en_o             // Write takes effect now
);
    ////////////////////////////////////////////////////////////////
    wire req;                              // New request pending

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // Write lands on the edge where the master sees ack
    assign wr_en_o = ce_i & wb_ack_o & wb_cyc_i & wb_stb_i
                   & wb_we_i & wb_sel_i[0];

    // Ack one cycle after request, dropped the cycle after
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= {`RASR_PAD24, `RASR_ZERO8};
        end
        else if (ce_i)
        begin
            wb_ack_o <= req;
            if (req)
                wb_dat_o <= {`RASR_PAD24, rd_data_i};
        end
    end
endmodule // rasr_wb_slave
`default_nettype wire

// ---- testbench/rasr_top_sva.sv ----
// Concurrent checks on the ports of the action register bank.
// Assumes it is bound into rasr_top with the same offset width.
`timescale 1ns/1ps
`default_nettype none
module rasr_top_sva #(
    parameter PH_W = 32                          // Offset width
) (
    input wire logic            clk_i,          // Clock
    input wire logic            rst_i,          // Reset
    input wire logic            ce_i,           // Enable
    input wire logic            wb_cyc_i,       // Cycle
    input wire logic            wb_stb_i,       // Strobe
    input wire logic            wb_we_i,        // Write
    input wire logic [13:0]     wb_adr_i,       // Address
    input wire logic [3:0]      wb_sel_i,       // Selects
    input wire logic [31:0]     wb_dat_i,       // Write data
    input wire logic [31:0]     wb_dat_o,       // Read data
    input wire logic            wb_ack_o,       // Ack
    input wire logic [PH_W-1:0] phase_offset_o, // Offset
    input wire logic [3:0]      launch_o,       // Launch
    input wire logic [3:0]      timeout_o,      // Timeout
    input wire logic [3:0]      override_o,     // Override
    input wire logic [3:0]      skip_o          // Bypass
);
////////////////////////////////////////
// Index and the edge where a write lands; sel[0] low drops it
wire logic [11:0] idx = wb_adr_i[13:2];
wire logic wr = ce_i & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_ack_o;
wire logic [15:0] act = {skip_o, override_o, timeout_o, launch_o};
default clocking cb @(posedge clk_i);
endclocking
default disable iff (rst_i);
// Request taken while ack is low
sequence s_take;
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
endsequence
// Write landing on the phase control
sequence s_phase;
    wr && idx == 12'ha0c;
endsequence
////////////////////////////////////////
ack_late_a: assert property (s_take |=> wb_ack_o)
    else $error("ack not one cycle after request");
ack_once_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
rd_pad_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
launch_map_a: assert property (wr && idx == 12'ha0d |=>
    launch_o == $past(wb_dat_i[3:0]))
    else $error("launch pulse wrong");
timeout_map_a: assert property (wr && idx == 12'ha0e |=>
    timeout_o == $past(wb_dat_i[3:0]))
    else $error("timeout pulse wrong");
ovr_map_a: assert property (wr && idx == 12'ha0f |=>
    override_o == $past(wb_dat_i[3:0]))
    else $error("override pulse wrong");
skip_map_a: assert property (wr && idx == 12'ha10 |=>
    skip_o == $past(wb_dat_i[3:0]))
    else $error("bypass pulse wrong");
act_clear_a: assert property (act != 16'h0000 && ce_i |=> act == 16'h0000)
    else $error("action bit did not clear");
act_cause_a: assert property (act != 16'h0000 && $past(ce_i) |-> $past(wr))
    else $error("action pulse without write");
phase_zero_a: assert property (s_phase ##0 wb_dat_i[2] |=>
    phase_offset_o == {PH_W{1'b0}})
    else $error("offset not zeroed");
phase_hold_a: assert property (!(wr && idx == 12'ha0c) |=> $stable(phase_offset_o))
    else $error("offset moved without write");
endmodule // rasr_top_sva
bind rasr_top rasr_top_sva #(.PH_W(PH_W)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .phase_offset_o(phase_offset_o),
    .launch_o(launch_o), .timeout_o(timeout_o),
    .override_o(override_o), .skip_o(skip_o)
);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the action register bank.
// Assumes one 20 MHz clock; the bench is the only bus master.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
////////////////////////////////////////
logic        clk_i = 1'b0;           // Clock
logic        rst_i = 1'b1;           // Held at start
logic        ce_i = 1'b1;            // High except for a spell in t_irq
logic        wb_cyc_i = 1'b0;        // Bus cycle
logic        wb_stb_i = 1'b0;        // Strobe
logic        wb_we_i = 1'b0;         // Direction
logic [13:0] wb_adr_i = 14'h0000;    // Byte address
logic [3:0]  wb_sel_i = 4'hf;        // Lanes
logic [31:0] wb_dat_i = 32'h00000000;// Write data
logic [15:0] ref_event_i = 16'h0000; // Event pulses
logic        irq_reset_all_i = 1'b0; // Global clear
logic [2:0]  ee = 3'h0;              // Fault, load, save
logic [31:0] q;                      // Last read data
wire logic [31:0] wb_dat_o;          // Read data
wire logic        wb_ack_o;          // Ack
wire logic        irq_o;             // Interrupt
wire logic [31:0] phase_offset_o;    // Offset
wire logic [3:0]  launch_o, timeout_o, override_o, skip_o;
wire logic [15:0] acts = {skip_o, override_o, timeout_o, launch_o}; // All action pulses
integer mismatches = 0;              // Failed checks
integer n_tests = 0;                 // All checks
integer cycles = 0;                  // Hang guard
////////////////////////////////////////
rasr_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ref_event_i(ref_event_i),
    .irq_reset_all_i(irq_reset_all_i), .ee_fault_i(ee[2]),
    .ee_load_i(ee[1]), .ee_save_i(ee[0]), .irq_o(irq_o),
    .phase_offset_o(phase_offset_o), .launch_o(launch_o),
    .timeout_o(timeout_o), .override_o(override_o), .skip_o(skip_o)
);
// Half period of 25 ns
always #25 clk_i = ~clk_i;
// Whole run needs well under 2000 cycles
always @(posedge clk_i)
begin
    cycles = cycles + 1;
    if (cycles == 4000)
    begin
        mismatches = mismatches + 1;
        final_report;
    end
end
////////////////////////////////////////
task final_report;
begin
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
end
endtask
// Case equality so an unknown never matches
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
begin
    n_tests = n_tests + 1;
    if (g !== e)
    begin
        mismatches = mismatches + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
end
endtask
// Classic cycle; released only at the edge where ack is seen
task wb(input logic w, input logic [11:0] ix, input logic [7:0] d);
begin
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {ix, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do
        @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
end
endtask
// Read and compare all 32 bits
task rd(input logic [11:0] ix, input logic [7:0] e);
begin
    wb(1'b0, ix, 8'h00);
    chk("read", {24'h000000, e}, q);
end
endtask
// Phase control write, then offset check
task ph(input logic [7:0] d, input logic [31:0] e);
begin
    wb(1'b1, 12'ha0c, d);
    #1;
    chk("offset", e, phase_offset_o);
end
endtask
// One-cycle event pulse
task ev(input logic [15:0] v);
begin
    @(posedge clk_i);
    ref_event_i <= v;
    @(posedge clk_i);
    ref_event_i <= 16'h0000;
end
endtask
////////////////////////////////////////
// Every action bit of the four pulse registers, upper bits set too
task t_actions;
    logic [11:0] r;
    logic [3:0]  b;
begin
    chk("idle", 32'h00000000, {override_o, skip_o, phase_offset_o[23:0]});
    for (r = 12'h000; r < 12'h004; r = r + 12'h001)
        for (b = 4'h0; b < 4'h4; b = b + 4'h1)
        begin
            wb(1'b1, 12'ha0d + r, 8'hf0 | (8'h01 << b));
            #1;
            chk("pulse", 32'h1 << {r[1:0], b[1:0]}, {16'h0, acts});
            @(posedge clk_i);
            #1;
            chk("cleared", 32'h0, {16'h0, acts});
            wb(1'b1, 12'ha0d + r, 8'h00);
            #1;
            chk("zero", 32'h0, {16'h0, acts});
            rd(12'ha0d + r, 8'h00);
        end
end
endtask
// Step, wrap, reset and a zero write
task t_phase;
begin
    wb(1'b1, 12'h314, 8'h34);
    wb(1'b1, 12'h315, 8'h12);
    ph(8'h01, 32'h00001234);
    ph(8'h01, 32'h00002468);
    ph(8'h02, 32'h00001234);
    ph(8'h00, 32'h00001234);
    ph(8'h04, 32'h00000000);
    ph(8'h02, 32'hffffedcc);
    ph(8'h07, 32'h00000000);
end
endtask
// Mask, set, clear by bit position, spare and read-only writes
task t_irq;
begin
    ev(16'h0109);
    rd(12'hd06, 8'h00);
    wb(1'b1, 12'h20d, 8'hff);
    wb(1'b1, 12'h20e, 8'hff);
    ev(16'h8009);
    rd(12'hd06, 8'h09);
    rd(12'hd07, 8'h80);
    chk("irq", 32'h00000001, {31'h00000000, irq_o});
    wb(1'b1, 12'ha08, 8'h01);
    rd(12'hd06, 8'h08);
    wb(1'b1, 12'ha0a, 8'hff);
    wb(1'b1, 12'ha0b, 8'hff);
    wb(1'b1, 12'hd06, 8'h00);
    wb(1'b1, 12'ha08, 8'hf7);
    rd(12'hd06, 8'h08);
    wb(1'b1, 12'ha09, 8'h80);
    rd(12'hd07, 8'h00);
    wb(1'b1, 12'ha08, 8'h08);
    rd(12'hd06, 8'h00);
    chk("irq", 32'h00000000, {31'h00000000, irq_o});
    ev(16'h0101);
    rd(12'hd07, 8'h01);
    @(posedge clk_i);
    irq_reset_all_i <= 1'b1;
    @(posedge clk_i);
    irq_reset_all_i <= 1'b0;
    rd(12'hd06, 8'h00);
    rd(12'hd07, 8'h00);
    // Event while the clock enable is low must not set a flag
    @(posedge clk_i);
    ce_i <= 1'b0;
    ev(16'h0001);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd(12'hd06, 8'h00);
end
endtask
// Status readback during save, load and fault; writes ignored
task t_ee;
begin
    @(posedge clk_i);
    ee <= 3'h5;
    rd(12'hd00, 8'h05);
    @(posedge clk_i);
    ee <= 3'h2;
    wb(1'b1, 12'hd00, 8'hff);
    rd(12'hd00, 8'h02);
    @(posedge clk_i);
    wb_sel_i <= 4'he;
    wb(1'b1, 12'ha0d, 8'h0f);
    #1;
    chk("dropped", 32'h00000000, {28'h0000000, launch_o});
    @(posedge clk_i);
    wb_sel_i <= 4'hf;
    rd(12'h3ff, 8'h00);
end
endtask
////////////////////////////////////////
initial
begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_actions;
    t_phase;
    t_irq;
    t_ee;
    final_report;
end
endmodule // tb_top
`default_nettype wire
